// ===== low_power_mode_controller.sv
// Operating-mode controller with AHB-Lite system control registers
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int WARMUP = WARMUP_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins and wake sources
  input wire logic slow_clock_pin,
  input wire logic tick_source_pin,
  input wire logic halt_release_pin,
  input wire logic wake_irq_request,
  // Mode outputs
  output clock_gate_s gates,
  output logic machine_cycle,
  output logic tick_irq_set,
  output logic tick_interrupt
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic slow_rise;
  logic tick_fall;
  logic halt_level;
  logic halt_rise;

  pin_sync slow_sync (.clk(core_clk), .reset_n(reset_n),
    .pin(slow_clock_pin), .level(), .rise(slow_rise), .fall());
  pin_sync tick_sync (.clk(core_clk), .reset_n(reset_n),
    .pin(tick_source_pin), .level(), .rise(), .fall(tick_fall));
  pin_sync halt_sync (.clk(core_clk), .reset_n(reset_n),
    .pin(halt_release_pin), .level(halt_level), .rise(halt_rise),
    .fall());

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pending;
  logic rd_wait;
  logic [7:0] bus_index;
  logic next_wr_pending;
  logic next_rd_wait;
  logic [7:0] next_bus_index;
  logic [31:0] next_hrdata;
  logic accept;
  logic [31:0] read_mux;

  logic [7:0] sys_one;
  logic [7:0] sys_two;
  logic [7:0] tick_ctrl;
  logic tick_latch;
  mode_e mode;
  logic tick_armed;

  assign accept = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;

  always_comb begin
    read_mux = 32'h0000_0000;
    case (bus_index)
      SYS_ONE_INDEX: read_mux = {24'h00_0000, sys_one & SYS_ONE_MASK};
      SYS_TWO_INDEX: begin
        read_mux = {24'h00_0000, sys_two & SYS_TWO_MASK};
        // Clock select reads back the clock actually in use
        read_mux[SEL_BIT] = gates.main_clock_slow;
      end
      MODE_STATUS_INDEX: read_mux = {27'h000_0000, tick_armed, mode};
      TICK_CTRL_INDEX: begin
        read_mux = {24'h00_0000, tick_ctrl & TICK_CTRL_MASK};
        read_mux[TICK_LATCH_BIT] = tick_latch;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // Reads take one wait state so hrdata comes from a flop
  always_comb begin
    next_wr_pending = accept & hwrite;
    next_rd_wait = accept & ~hwrite;
    next_bus_index = accept ? haddr[9:2] : bus_index;
    next_hrdata = rd_wait ? read_mux : hrdata;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pending <= 1'b0;
      rd_wait <= 1'b0;
      bus_index <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pending <= next_wr_pending;
      rd_wait <= next_rd_wait;
      bus_index <= next_bus_index;
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  logic stop_req;
  logic doze_req;
  logic halt_req;
  logic fast_on;
  logic slow_on;
  logic sel_slow;
  logic clr_stop;
  logic clr_doze;
  logic clr_halt;
  logic halt_release;
  logic [15:0] warm_count;
  logic [15:0] next_warm_count;
  logic next_tick_armed;
  logic next_tick_irq_set;
  mode_e next_mode;

  assign stop_req = sys_one[STOP_BIT];
  assign doze_req = sys_two[IDLE_BIT];
  assign halt_req = sys_two[PERIPH_HALT_BIT];
  assign fast_on = sys_two[FAST_OSC_BIT];
  assign slow_on = sys_two[SLOW_OSC_BIT];
  assign sel_slow = sys_two[SEL_BIT];
  assign halt_release = sys_one[RELM_BIT] ? halt_level : halt_rise;

  always_comb begin
    next_mode = mode;
    next_tick_armed = tick_armed;
    next_warm_count = warm_count;
    next_tick_irq_set = 1'b0;
    clr_stop = 1'b0;
    clr_doze = 1'b0;
    clr_halt = 1'b0;
    case (mode)
      run_fast_single: begin
        if (stop_req) begin
          next_mode = deep_halt;
        end else if (halt_req) begin
          next_mode = doze_tick_only_fast;
          next_tick_armed = tick_ctrl[TICK_EN_BIT];
        end else if (doze_req) begin
          next_mode = doze_fast_single;
        end else if (slow_on) begin
          next_mode = run_fast_dual;
        end
      end
      doze_fast_single: begin
        if (wake_irq_request) begin
          next_mode = run_fast_single;
          clr_doze = 1'b1;
        end
      end
      doze_tick_only_fast, doze_tick_only_slow: begin
        // Edge arrives only via the synchroniser
        if (tick_fall) begin
          next_mode = (mode == doze_tick_only_fast) ?
            run_fast_single : run_slow_only;
          clr_halt = 1'b1;
          next_tick_irq_set = tick_armed;
          next_tick_armed = 1'b0;
        end
      end
      run_fast_dual: begin
        if (stop_req) begin
          next_mode = deep_halt;
        end else if (doze_req) begin
          next_mode = doze_fast_dual;
        end else if (sel_slow) begin
          next_mode = run_slow_dual;
        end else if (!slow_on) begin
          next_mode = run_fast_single;
        end
      end
      doze_fast_dual: begin
        if (wake_irq_request) begin
          next_mode = run_fast_dual;
          clr_doze = 1'b1;
        end
      end
      run_slow_dual: begin
        if (stop_req) begin
          next_mode = deep_halt;
        end else if (doze_req) begin
          next_mode = doze_slow_dual;
        end else if (!sel_slow) begin
          next_mode = run_fast_dual;
        end else if (!fast_on) begin
          next_mode = run_slow_only;
        end
      end
      doze_slow_dual: begin
        if (wake_irq_request) begin
          next_mode = run_slow_dual;
          clr_doze = 1'b1;
        end
      end
      run_slow_only: begin
        if (stop_req) begin
          next_mode = deep_halt;
        end else if (halt_req) begin
          next_mode = doze_tick_only_slow;
          next_tick_armed = tick_ctrl[TICK_EN_BIT];
        end else if (doze_req) begin
          next_mode = doze_slow_only;
        end else if (fast_on) begin
          next_mode = run_slow_dual;
        end
      end
      doze_slow_only: begin
        if (wake_irq_request) begin
          next_mode = run_slow_only;
          clr_doze = 1'b1;
        end
      end
      deep_halt: begin
        if (halt_release) begin
          next_mode = warm_up;
          next_warm_count = 16'(WARMUP - 1);
        end
      end
      warm_up: begin
        if (warm_count == 16'h0000) begin
          clr_stop = 1'b1;
          if (sys_one[RETM_BIT]) begin
            next_mode = run_slow_only;
          end else if (slow_on) begin
            next_mode = run_fast_dual;
          end else begin
            next_mode = run_fast_single;
          end
        end else begin
          next_warm_count = warm_count - 16'h0001;
        end
      end
      default: next_mode = run_fast_single;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock gates, derived from the next mode so they change with it
  // ----------------------------------------------------------------
  clock_gate_s next_gates;
  logic slow_main;
  logic halted;

  always_comb begin
    slow_main = next_mode inside {run_slow_dual, doze_slow_dual,
      run_slow_only, doze_slow_only, doze_tick_only_slow};
    halted = next_mode inside {deep_halt, warm_up};
    next_gates.main_clock_slow = slow_main;
    next_gates.fast_osc_enable = !(next_mode inside {run_slow_only,
      doze_slow_only, doze_tick_only_slow, deep_halt});
    next_gates.slow_osc_enable = (next_mode != deep_halt) &&
      (slow_main || (next_mode inside {run_fast_dual, doze_fast_dual}) ||
      (next_mode == warm_up && slow_on));
    next_gates.cpu_run = next_mode inside {run_fast_single,
      run_fast_dual, run_slow_dual, run_slow_only};
    next_gates.watchdog_run = next_gates.cpu_run;
    next_gates.periph_clock_run = !halted && !(next_mode inside
      {doze_tick_only_fast, doze_tick_only_slow});
    next_gates.tick_timer_run = !halted;
    // Stages one to six only run on the fast clock
    next_gates.divider_low_run = !slow_main && next_mode != deep_halt;
    next_gates.xtal_pins_as_port = !slow_on;
  end

  // ----------------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------------
  logic [1:0] state_count;
  logic [1:0] next_state_count;
  logic main_edge;
  logic next_machine_cycle;

  // Core clock stands in for the fast clock; slow edges come synced
  assign main_edge = gates.main_clock_slow ? slow_rise :
    (mode != deep_halt && mode != warm_up);

  always_comb begin
    next_state_count = state_count;
    next_machine_cycle = 1'b0;
    if (main_edge) begin
      next_state_count = state_count + 2'd1;
      next_machine_cycle = (state_count == 2'(STATES_PER_CYCLE - 1));
    end
  end

  // ----------------------------------------------------------------
  // Registers: software writes with hardware self-clears
  // ----------------------------------------------------------------
  logic [7:0] next_sys_one;
  logic [7:0] next_sys_two;
  logic [7:0] next_tick_ctrl;
  logic next_tick_latch;
  logic wr_one;
  logic wr_two;
  logic wr_tick;

  assign wr_one = wr_pending && bus_index == SYS_ONE_INDEX;
  assign wr_two = wr_pending && bus_index == SYS_TWO_INDEX;
  assign wr_tick = wr_pending && bus_index == TICK_CTRL_INDEX;

  always_comb begin
    next_sys_one = sys_one;
    next_sys_two = sys_two;
    next_tick_ctrl = tick_ctrl;
    // A fresh software write wins over a self-clear in the same cycle
    if (clr_stop) next_sys_one[STOP_BIT] = 1'b0;
    if (clr_doze) next_sys_two[IDLE_BIT] = 1'b0;
    if (clr_halt) next_sys_two[PERIPH_HALT_BIT] = 1'b0;
    if (wr_one) next_sys_one = hwdata[7:0] & SYS_ONE_MASK;
    if (wr_two) next_sys_two = hwdata[7:0] & SYS_TWO_MASK;
    if (wr_tick) next_tick_ctrl = hwdata[7:0] & TICK_CTRL_MASK;
    // Latch clears by writing one; a set in that cycle wins
    next_tick_latch = (tick_latch &
      !(wr_tick && hwdata[TICK_LATCH_BIT])) | tick_irq_set;
  end

  assign tick_interrupt = tick_latch & tick_ctrl[GLOBAL_IRQ_BIT] &
    tick_ctrl[TICK_IRQ_EN_BIT] & tick_ctrl[TICK_EN_BIT];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= run_fast_single;
      sys_one <= SYS_ONE_RESET;
      sys_two <= SYS_TWO_RESET;
      tick_ctrl <= TICK_CTRL_RESET;
      tick_latch <= 1'b0;
      tick_armed <= 1'b0;
      tick_irq_set <= 1'b0;
      warm_count <= 16'h0000;
      state_count <= 2'd0;
      machine_cycle <= 1'b0;
      gates <= '{fast_osc_enable: 1'b1, cpu_run: 1'b1,
        watchdog_run: 1'b1, periph_clock_run: 1'b1,
        tick_timer_run: 1'b1, divider_low_run: 1'b1,
        xtal_pins_as_port: 1'b1, default: 1'b0};
    end else begin
      mode <= next_mode;
      sys_one <= next_sys_one;
      sys_two <= next_sys_two;
      tick_ctrl <= next_tick_ctrl;
      tick_latch <= next_tick_latch;
      tick_armed <= next_tick_armed;
      tick_irq_set <= next_tick_irq_set;
      warm_count <= next_warm_count;
      state_count <= next_state_count;
      machine_cycle <= next_machine_cycle;
      gates <= next_gates;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_tick_entry_fast: assert property (
    mode == run_fast_single && halt_req && !stop_req
    |=> mode == doze_tick_only_fast && !gates.periph_clock_run
        && !gates.cpu_run && gates.tick_timer_run)
    else $error("tick doze not entered from fast single");
  chk_tick_exit_fast: assert property (
    mode == doze_tick_only_fast && tick_fall
    |=> mode == run_fast_single && gates.periph_clock_run && !halt_req)
    else $error("tick doze did not resume fast single");
  chk_tick_latch_set: assert property (
    mode == doze_tick_only_fast && tick_fall && tick_armed
    |=> tick_irq_set ##1 tick_latch)
    else $error("tick latch not set after armed doze");
  chk_tick_irq_gate: assert property (
    tick_irq_set && tick_ctrl[GLOBAL_IRQ_BIT] && tick_ctrl[TICK_IRQ_EN_BIT]
    && tick_ctrl[TICK_EN_BIT] && !wr_tick |=> tick_interrupt)
    else $error("tick interrupt missing with all enables");
  chk_slow_select: assert property (
    mode == run_fast_dual && sel_slow && !doze_req && !stop_req
    |=> mode == run_slow_dual && gates.main_clock_slow)
    else $error("clock select did not reach slow dual");
  chk_divider_stop: assert property (
    gates.main_clock_slow |-> !gates.divider_low_run)
    else $error("low divider stages run on slow clock");
  chk_halt_osc_off: assert property (
    $rose(mode == deep_halt) |-> !gates.fast_osc_enable
    && !gates.slow_osc_enable && $stable(sys_two))
    else $error("oscillators running in deep halt");
  chk_doze_release: assert property (
    mode == doze_fast_single && wake_irq_request && !wr_two
    |=> mode == run_fast_single && !doze_req)
    else $error("doze release did not clear request bit");
  chk_halt_release: assert property (
    mode == deep_halt && sys_one[RELM_BIT] && halt_level
    |=> mode == warm_up)
    else $error("level release did not start warm-up");
  chk_cycle_four: assert property (
    machine_cycle && mode == run_fast_single |=> !machine_cycle [*3])
    else $error("machine cycle shorter than four periods");

  cover property (mode == doze_tick_only_fast ##1 mode == run_fast_single);
  cover property (mode == warm_up ##1 mode == run_slow_only);
  cover property (mode == run_slow_dual ##1 mode == run_slow_only);
  cover property (mode == doze_slow_dual ##1 mode == run_slow_dual);
endmodule
`default_nettype wire

// ===== lpm_pkg.sv
// Shared constants, mode enumeration and clock-gate carrier
package lpm_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SYS_ONE_INDEX = 8'h38;
  localparam logic [7:0] SYS_TWO_INDEX = 8'h39;
  localparam logic [7:0] MODE_STATUS_INDEX = 8'h3a;
  localparam logic [7:0] TICK_CTRL_INDEX = 8'h3b;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SYS_ONE_RESET = 8'h00;
  localparam logic [7:0] SYS_TWO_RESET = 8'h80;
  localparam logic [7:0] TICK_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STOP_BIT = 7;
  localparam int RELM_BIT = 6;
  localparam int RETM_BIT = 5;
  localparam logic [7:0] SYS_ONE_MASK = 8'hfc;
  localparam int FAST_OSC_BIT = 7;
  localparam int SLOW_OSC_BIT = 6;
  localparam int SEL_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int PERIPH_HALT_BIT = 2;
  localparam logic [7:0] SYS_TWO_MASK = 8'hf4;
  localparam int TICK_EN_BIT = 0;
  localparam int TICK_IRQ_EN_BIT = 1;
  localparam int GLOBAL_IRQ_BIT = 2;
  localparam int TICK_LATCH_BIT = 3;
  localparam logic [7:0] TICK_CTRL_MASK = 8'h07;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int STATES_PER_CYCLE = 4;
  localparam int WARMUP_CYCLES = 16;

  typedef enum logic [3:0] {
    run_fast_single,
    doze_fast_single,
    doze_tick_only_fast,
    run_fast_dual,
    doze_fast_dual,
    run_slow_dual,
    doze_slow_dual,
    run_slow_only,
    doze_slow_only,
    doze_tick_only_slow,
    deep_halt,
    warm_up
  } mode_e;

  typedef struct packed {
    logic fast_osc_enable;
    logic slow_osc_enable;
    logic main_clock_slow;
    logic cpu_run;
    logic watchdog_run;
    logic periph_clock_run;
    logic tick_timer_run;
    logic divider_low_run;
    logic xtal_pins_as_port;
  } clock_gate_s;

endpackage

// ===== pin_sync.sv
// Two-flop pin synchroniser with edge detection on the stable copy
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous pin
  input wire logic pin,
  // Synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edges compare the second stage with its delayed copy, never the first
  assign level = stable;
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lpm_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int WARM = 2;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic slow_clock_pin = 1'b0;
  logic tick_source_pin = 1'b1;
  logic halt_release_pin = 1'b0;
  logic wake_irq_request = 1'b0;
  clock_gate_s gates;
  logic machine_cycle;
  logic tick_irq_set;
  logic tick_interrupt;
  logic rd_phase = 1'b0;
  logic gate_req = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [31:0] gate_q[$];
  int checks = 0;
  int mismatches = 0;
  int irq_count = 0;
  int mc_count = 0;
  int snap;
  logic [31:0] rnd;

  assign hready = hreadyout;
  always #12.5 core_clk = ~core_clk;
  // Slow oscillator runs free, its period sixteen core clock periods
  always #200 slow_clock_pin = ~slow_clock_pin;

  low_power_mode_controller #(.WARMUP(WARM)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .slow_clock_pin(slow_clock_pin),
    .tick_source_pin(tick_source_pin),
    .halt_release_pin(halt_release_pin),
    .wake_irq_request(wake_irq_request), .gates(gates),
    .machine_cycle(machine_cycle), .tick_irq_set(tick_irq_set),
    .tick_interrupt(tick_interrupt)
  );

  // ------------------------------------------------------------
  // Compare, bus and closing tasks
  // ------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                           input string msg);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg,
               got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic [31:0] m);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    if (!w) begin
      exp_q.push_back(exp);
      mask_q.push_back(m);
    end
    rd_phase <= !w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    ahb(1'b1, idx, wd, 32'h0000_0000, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [31:0] m);
    ahb(1'b0, idx, 32'h0000_0000, exp, m);
  endtask

  // Expected value is {tick_interrupt, gates}
  task automatic expect_gates(input logic [31:0] e);
    gate_q.push_back(e);
    gate_req <= 1'b1;
    @(posedge core_clk);
    gate_req <= 1'b0;
  endtask

  task automatic tick_fall();
    snap = irq_count;
    tick_source_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    tick_source_pin <= 1'b1;
  endtask

  // One-cycle interrupt request, then time for the mode to settle
  task automatic wake();
    wake_irq_request <= 1'b1;
    @(posedge core_clk);
    wake_irq_request <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Output monitor: takes the oldest note when a result appears
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (tick_irq_set === 1'b1) irq_count++;
    if (machine_cycle === 1'b1) mc_count++;
    if (rd_phase && hreadyout === 1'b1)
      check_val(hrdata & mask_q.pop_front(), exp_q.pop_front(), "read");
    if (gate_req)
      check_val({22'h0, tick_interrupt, gates}, gate_q.pop_front(), "gates");
  end

  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    $display("CHECK FAILED at %0t: timeout", $time);
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h5a8719b6));
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(SYS_ONE_INDEX, 32'h0000_0000, 32'h0000_00ff);
    rd(SYS_TWO_INDEX, 32'h0000_0080, 32'h0000_00ff);
    rd(MODE_STATUS_INDEX, 32'h0000_0000, 32'h0000_000f);
    rd(8'h3f, 32'h0000_0000, 32'hffff_ffff);
    expect_gates(32'h0000_013f);
    #1 snap = mc_count;
    repeat (40) @(posedge core_clk);
    #1 check_val(32'(mc_count - snap), 32'h0000_000a, "cycles");
    // Armed tick-only doze from fast single run
    rnd = $urandom;
    wr(TICK_CTRL_INDEX, {rnd[31:4], 4'h7});
    rd(TICK_CTRL_INDEX, 32'h0000_0007, 32'h0000_00ff);
    wr(SYS_TWO_INDEX, 32'h0000_0084);
    rd(MODE_STATUS_INDEX, 32'h0000_0002, 32'h0000_000f);
    expect_gates(32'h0000_0107);
    tick_fall();
    rd(MODE_STATUS_INDEX, 32'h0000_0000, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_0080, 32'h0000_00ff);
    expect_gates(32'h0000_033f);
    rd(TICK_CTRL_INDEX, 32'h0000_000f, 32'h0000_00ff);
    check_val(32'(irq_count - snap), 32'h0000_0001, "irq set");
    wr(TICK_CTRL_INDEX, 32'h0000_0003);
    expect_gates(32'h0000_013f);
    wr(TICK_CTRL_INDEX, 32'h0000_000f);
    expect_gates(32'h0000_013f);
    wr(TICK_CTRL_INDEX, 32'h0000_0000);
    // Fast single doze released by an interrupt request
    wr(SYS_TWO_INDEX, 32'h0000_0090);
    rd(MODE_STATUS_INDEX, 32'h0000_0001, 32'h0000_000f);
    expect_gates(32'h0000_010f);
    wake();
    rd(MODE_STATUS_INDEX, 32'h0000_0000, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_0080, 32'h0000_00ff);
    // Dual-clock and slow modes; reserved bits carry random noise
    rnd = $urandom;
    wr(SYS_TWO_INDEX, {rnd[31:8], 8'hc0 | (rnd[7:0] & 8'h0b)});
    rd(MODE_STATUS_INDEX, 32'h0000_0003, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_00c0, 32'h0000_00ff);
    expect_gates(32'h0000_01be);
    wr(SYS_TWO_INDEX, 32'h0000_00d0);
    rd(MODE_STATUS_INDEX, 32'h0000_0004, 32'h0000_000f);
    wake();
    rd(MODE_STATUS_INDEX, 32'h0000_0003, 32'h0000_000f);
    wr(SYS_TWO_INDEX, 32'h0000_00e0);
    rd(MODE_STATUS_INDEX, 32'h0000_0005, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_00e0, 32'h0000_00ff);
    wr(SYS_TWO_INDEX, 32'h0000_0060);
    rd(MODE_STATUS_INDEX, 32'h0000_0007, 32'h0000_000f);
    expect_gates(32'h0000_00fc);
    // Let the slow cycle counter settle, then count whole slow periods
    repeat (64) @(posedge core_clk);
    #1 snap = mc_count;
    repeat (128) @(posedge core_clk);
    #1 check_val(32'(mc_count - snap), 32'h0000_0002, "slow cycles");
    wr(SYS_TWO_INDEX, 32'h0000_00e0);
    rd(MODE_STATUS_INDEX, 32'h0000_0005, 32'h0000_000f);
    wr(SYS_TWO_INDEX, 32'h0000_00f0);
    rd(MODE_STATUS_INDEX, 32'h0000_0006, 32'h0000_000f);
    wake();
    rd(MODE_STATUS_INDEX, 32'h0000_0005, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_00e0, 32'h0000_00ff);
    wr(SYS_TWO_INDEX, 32'h0000_0060);
    // Unarmed tick-only doze from slow-only run
    wr(SYS_TWO_INDEX, 32'h0000_0064);
    rd(MODE_STATUS_INDEX, 32'h0000_0009, 32'h0000_000f);
    tick_fall();
    rd(MODE_STATUS_INDEX, 32'h0000_0007, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_0060, 32'h0000_00ff);
    check_val(32'(irq_count - snap), 32'h0000_0000, "irq set");
    // Slow doze released by an interrupt request
    wr(SYS_TWO_INDEX, 32'h0000_0070);
    rd(MODE_STATUS_INDEX, 32'h0000_0008, 32'h0000_000f);
    expect_gates(32'h0000_00cc);
    wake();
    rd(MODE_STATUS_INDEX, 32'h0000_0007, 32'h0000_000f);
    rd(SYS_TWO_INDEX, 32'h0000_0060, 32'h0000_00ff);
    // Deep halt, level release, return to slow-only run
    wr(SYS_ONE_INDEX, 32'h0000_00e0);
    rd(MODE_STATUS_INDEX, 32'h0000_000a, 32'h0000_000f);
    expect_gates(32'h0000_0000);
    halt_release_pin <= 1'b1;
    repeat (WARM + 10) @(posedge core_clk);
    rd(MODE_STATUS_INDEX, 32'h0000_0007, 32'h0000_000f);
    rd(SYS_ONE_INDEX, 32'h0000_0060, 32'h0000_00ff);
    halt_release_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule
`default_nettype wire
